// file: ascs_buf2.sv
// Two-entry result buffer with valid/ready on both sides.
// Assumes both sides run on the core clock.
`timescale 1ns/1ps

module ascs_buf2
	import ascs_pkg::*;
(
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_in_valid,
	input  ascs_result_s      i_in_data,
	output logic              o_in_ready,
	output logic              o_out_valid,
	output ascs_result_s      o_out_data,
	input  wire logic         i_out_ready
);

	ascs_result_s mem_reg [2];
	logic         wr_ptr_reg;
	logic         rd_ptr_reg;
	logic [1:0]   count_reg;
	logic         push;
	logic         pop;

	assign o_in_ready  = (count_reg != 2'h2);
	assign o_out_valid = (count_reg != 2'h0);
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_reg <= 1'h0;
			rd_ptr_reg <= 1'h0;
			count_reg  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + {1'h0, push} - {1'h0, pop};
		end
	end

endmodule

// file: ascs_host_model.sv
// Host side of the serial link: makes the serial clock in frames and a few edges while deselected,
// drives chip select, frame sync, serial data and the extended start.
// Assumes the sequencer samples serial data on falling serial clock edges.
`timescale 1ns/1ps

module ascs_host_model (
	output logic      o_sclk,
	output logic      o_chip_select_n,
	output logic      o_frame_sync,
	output logic      o_serial_data_in,
	output logic      o_extended_sample_start,
	input  wire logic i_serial_data_out,
	input  wire logic i_serial_data_out_oe
);
	int   falls = 0;
	logic sdo_last = 1'b0;
	// A released output reads as a changing pattern, never as the last bit
	wire  sdo_wire = i_serial_data_out_oe ? i_serial_data_out : ~sdo_last;

	initial begin
		o_sclk                  = 1'b0;
		o_chip_select_n         = 1'b1;
		o_frame_sync            = 1'b1;
		o_serial_data_in        = 1'b0;
		o_extended_sample_start = 1'b1;
	end

	always @(negedge o_sclk) sdo_last <= sdo_wire;

	// ==================================================================
	// One frame of n falls, plus a lead fall with frame sync; replies are taken just before 16 of them
	task automatic frame(input int n, input logic [15:0] tx, input bit fsm,
		output logic [15:0] rx);
		rx = 16'h0000;
		if (!fsm) begin
			o_chip_select_n = 1'b1;
			o_frame_sync    = 1'b1;
			#50;
			// Clocks while deselected let the link see a result queued
			// while the clock stood still; the device ignores them
			repeat (2) begin
				o_sclk = 1'b1;
				#62.5;
				o_sclk = 1'b0;
				#62.5;
			end
		end
		o_chip_select_n = 1'b0;
		o_frame_sync    = !fsm;
		#100;
		if (fsm) begin
			o_sclk = 1'b1;
			#62.5;
			o_sclk = 1'b0;
			#62.5;
		end
		for (int i = 0; i < n; i++) begin
			o_sclk           = 1'b1;
			o_serial_data_in = (i < 16) ? tx[15 - i] : i[0];
			if (fsm) o_frame_sync = (i == 0);
			#62.5;
			if (i >= int'(fsm) && i < 16 + int'(fsm)) rx = {rx[14:0], sdo_wire};
			o_sclk = 1'b0;
			falls  = i + 1;
			#62.5;
		end
		#100;
		if (!fsm) o_chip_select_n = 1'b1;
	endtask

	// ==================================================================
	// Activity while deselected
	task automatic noise();
		o_chip_select_n = 1'b1;
		for (int i = 0; i < 20; i++) begin
			o_sclk           = i[0];
			o_frame_sync     = i[1];
			o_serial_data_in = i[2];
			#62.5;
		end
		o_sclk = 1'b0;
	endtask

	task automatic ext_pulse(input realtime low_ns);
		o_extended_sample_start = 1'b0;
		#(low_ns);
		o_extended_sample_start = 1'b1;
	endtask
endmodule

// file: ascs_params.svh
// Constants of the serial conversion sequencer: frame counts, conversion
// lengths and the core timing figures used to derive cycle counts.
// Assumes a 100 MHz core clock; included by the package and the top module.
`ifndef ASCS_PARAMS_SVH
`define ASCS_PARAMS_SVH

// ==========================================================================
// Frame and code layout
`define ASCS_FRAME_BITS    16
`define ASCS_CODE_BITS     14
`define ASCS_SHORT_SCLKS   6'h10
`define ASCS_LONG_SCLKS    6'h30
`define ASCS_CNT_MAX       6'h3F
`define ASCS_ZERO_CODE     14'h2000

// ==========================================================================
// Conversion lengths
`define ASCS_OSC_PER_14    18
`define ASCS_OSC_PER_12    13
`define ASCS_SCLK_PER_14   7'h48
`define ASCS_SCLK_PER_12   7'h34
`define ASCS_OSC_DIV       4
`define ASCS_TAIL_NS       15
`define ASCS_CLK_NS        10
`define ASCS_TAIL_CYC      ((`ASCS_TAIL_NS + `ASCS_CLK_NS - 1) / `ASCS_CLK_NS)

`endif

// file: ascs_pkg.sv
// Types shared by the sequencer and its result buffer.
// Assumes ascs_params.svh is on the include path.
`include "ascs_params.svh"

package ascs_pkg;

	// ======================================================================
	// Trigger modes and conversion states
	typedef enum logic [1:0] {
		TRIG_CS  = 2'h0,
		TRIG_FS  = 2'h1,
		TRIG_EXT = 2'h2
	} ascs_trig_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_CONV  = 2'h1,
		ST_TAIL  = 2'h3,
		ST_STORE = 2'h2
	} ascs_state_e;

	// ======================================================================
	// Carriers
	typedef struct packed {
		logic [`ASCS_CODE_BITS-1:0] code;
	} ascs_result_s;

	typedef struct packed {
		ascs_trig_e trig;
		logic       long_sample;
		logic       sclk_conv;
		logic       res_12bit;
	} ascs_cfg_s;

endpackage

// file: ascs_sequencer.sv
// Serial host interface and conversion sequencer of a multichannel converter.
// Assumes the host launches frame_sync, chip select and serial_data_in relative
// to the serial clock; mode and variant straps are quasi-static pins.
// Function
// - Capture serial_data_in on serial clock falling edge
// - Launch serial_data_out after serial clock rising edge
// - End_of_conversion low after 16th/48th falling edge
// - Done flag low one conversion time later
// - Oscillator conversion 18 or 13 periods plus 15ns
// - Serial-clock conversion 72 or 52 periods plus 15ns
// - Chip select high: output released, inputs ignored
// - Chip select fall starts cycle; frame_sync held high
// - Results coded as offset binary
// - Frame_sync rise starts cycle; chip select may stay low
// - Extended start rise: done flag one conversion later
`timescale 1ns/1ps
`include "ascs_params.svh"

module ascs_sequencer
	import ascs_pkg::*;
#(
	parameter int OSC_DIV = `ASCS_OSC_DIV
)(
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_sclk,
	input  wire logic                       i_chip_select_n,
	input  wire logic                       i_frame_sync,
	input  wire logic                       i_serial_data_in,
	input  wire logic                       i_extended_sample_start,
	input  wire logic [1:0]                 i_trigger_mode,
	input  wire logic                       i_long_sample,
	input  wire logic                       i_sclk_conv,
	input  wire logic                       i_res_12bit,
	input  wire logic [`ASCS_CODE_BITS-1:0] i_analog_code,
	output logic                            o_serial_data_out,
	output logic                            o_serial_data_out_oe,
	output logic                            o_end_of_conversion,
	output logic                            o_conversion_done_n,
	output logic [`ASCS_FRAME_BITS-1:0]     o_sdi_word
);

	localparam int TAIL_CYC = `ASCS_TAIL_CYC;
	localparam int OSC14    = `ASCS_OSC_PER_14 * OSC_DIV;
	localparam int OSC12    = `ASCS_OSC_PER_12 * OSC_DIV;

	// ======================================================================
	// Link domain: serial clock side
	logic [1:0]                 lcfg_meta_reg;
	logic [1:0]                 lcfg_sync_reg;
	logic                       lreq_meta_reg;
	logic                       lreq_sync_reg;
	logic [5:0]                 fall_cnt_reg;
	logic [5:0]                 fall_cnt_next;
	logic                       fs_prev_reg;
	logic                       fs_start;
	logic                       conv_tgl_reg;
	logic                       fstart_tgl_reg;
	logic [`ASCS_FRAME_BITS-1:0] sdi_shift_reg;
	logic [`ASCS_FRAME_BITS-1:0] sdi_word_reg;
	logic [5:0]                 target;
	logic                       loaded_reg;
	logic [`ASCS_FRAME_BITS-1:0] sdo_shift_reg;
	logic                       frame_seen_reg;
	logic                       ack_tgl_reg;
	logic                       conv_seen_reg;
	logic                       sconv_run_reg;
	logic [6:0]                 sconv_cnt_reg;
	logic                       sdone_tgl_reg;
	logic                       load_now;
	logic                       take_word;
	logic                       link_fs_mode;
	logic [6:0]                 sconv_target;

	// Core-side word handed to the link, stable while the request is open
	ascs_result_s               hold_reg;
	logic                       req_tgl_reg;

	assign link_fs_mode = lcfg_sync_reg[1];
	assign target       = lcfg_sync_reg[0] ? `ASCS_LONG_SCLKS : `ASCS_SHORT_SCLKS;

	// Variant strap seen by the link; it only sets how long the counter runs
	logic lres_meta_reg;
	logic lres_sync_reg;

	assign sconv_target = lres_sync_reg ? `ASCS_SCLK_PER_12 : `ASCS_SCLK_PER_14;

	always_ff @(posedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			lcfg_meta_reg <= 2'h0;
			lcfg_sync_reg <= 2'h0;
			lres_meta_reg <= 1'h0;
			lres_sync_reg <= 1'h0;
			lreq_meta_reg <= 1'h0;
			lreq_sync_reg <= 1'h0;
		end else begin
			lcfg_meta_reg <= {(i_trigger_mode == TRIG_FS), i_long_sample};
			lcfg_sync_reg <= lcfg_meta_reg;
			lres_meta_reg <= i_res_12bit;
			lres_sync_reg <= lres_meta_reg;
			lreq_meta_reg <= req_tgl_reg;
			lreq_sync_reg <= lreq_meta_reg;
		end
	end

	// ======================================================================
	// Falling edge: frame detection, bit count, input capture
	assign fs_start = link_fs_mode && i_frame_sync && !fs_prev_reg;

	always_comb begin
		fall_cnt_next = fall_cnt_reg;
		if (fs_start) begin
			fall_cnt_next = 6'h01;
		end else if ((fall_cnt_reg != 6'h00 || !link_fs_mode) &&
			fall_cnt_reg != `ASCS_CNT_MAX) begin
			fall_cnt_next = fall_cnt_reg + 6'h01;
		end
	end

	// Chip select high clears the frame without needing a clock edge
	always_ff @(negedge i_sclk or posedge i_rst or posedge i_chip_select_n) begin
		if (i_rst) begin
			fall_cnt_reg  <= 6'h00;
			fs_prev_reg   <= 1'h1;
			sdi_shift_reg <= 16'h0000;
		end else if (i_chip_select_n) begin
			fall_cnt_reg  <= 6'h00;
			fs_prev_reg   <= 1'h1;
			sdi_shift_reg <= 16'h0000;
		end else begin
			fall_cnt_reg  <= fall_cnt_next;
			fs_prev_reg   <= i_frame_sync;
			sdi_shift_reg <= {sdi_shift_reg[`ASCS_FRAME_BITS-2:0], i_serial_data_in};
		end
	end

	// Toggles must survive chip select, so they see only the core reset
	always_ff @(negedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			conv_tgl_reg   <= 1'h0;
			fstart_tgl_reg <= 1'h0;
			sdi_word_reg   <= 16'h0000;
		end else if (!i_chip_select_n) begin
			if (fall_cnt_next == target && fall_cnt_reg != target) begin
				conv_tgl_reg <= ~conv_tgl_reg;
			end
			if (fs_start) begin
				fstart_tgl_reg <= ~fstart_tgl_reg;
			end
			if (fall_cnt_next == 6'h10 && fall_cnt_reg != 6'h10) begin
				sdi_word_reg <= {sdi_shift_reg[`ASCS_FRAME_BITS-2:0], i_serial_data_in};
			end
		end
	end

	assign o_sdi_word = sdi_word_reg;

	// ======================================================================
	// Rising edge: output shifter and serial-clock conversion timer
	// A result queued while the clock stood still shows only after two rises
	assign load_now  = !i_chip_select_n &&
		(link_fs_mode ? (fstart_tgl_reg != frame_seen_reg) : !loaded_reg);
	assign take_word = load_now && (lreq_sync_reg != ack_tgl_reg);

	always_ff @(posedge i_sclk or posedge i_rst or posedge i_chip_select_n) begin
		if (i_rst) begin
			loaded_reg    <= 1'h0;
			sdo_shift_reg <= 16'h0000;
		end else if (i_chip_select_n) begin
			loaded_reg    <= 1'h0;
			sdo_shift_reg <= 16'h0000;
		end else if (load_now) begin
			loaded_reg    <= 1'h1;
			// An empty buffer sends zeros rather than repeating a stale word
			sdo_shift_reg <= take_word ? {hold_reg.code, 2'h0} : 16'h0000;
		end else begin
			sdo_shift_reg <= {sdo_shift_reg[`ASCS_FRAME_BITS-2:0], 1'h0};
		end
	end

	assign o_serial_data_out = sdo_shift_reg[`ASCS_FRAME_BITS-1];

	always_ff @(posedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			frame_seen_reg <= 1'h0;
			ack_tgl_reg    <= 1'h0;
		end else begin
			if (load_now && link_fs_mode) begin
				frame_seen_reg <= fstart_tgl_reg;
			end
			if (take_word) begin
				ack_tgl_reg <= ~ack_tgl_reg;
			end
		end
	end

	// Host must keep the serial clock running through the conversion here
	always_ff @(posedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			conv_seen_reg <= 1'h0;
			sconv_run_reg <= 1'h0;
			sconv_cnt_reg <= 7'h00;
			sdone_tgl_reg <= 1'h0;
		end else if (conv_tgl_reg != conv_seen_reg) begin
			conv_seen_reg <= conv_tgl_reg;
			sconv_run_reg <= 1'h1;
			// First rise lags the start fall by half a period: count it twice
			sconv_cnt_reg <= 7'h02;
		end else if (sconv_run_reg) begin
			if (sconv_cnt_reg == sconv_target) begin
				sconv_run_reg <= 1'h0;
				sdone_tgl_reg <= ~sdone_tgl_reg;
			end else begin
				sconv_cnt_reg <= sconv_cnt_reg + 7'h01;
			end
		end
	end

	// ======================================================================
	// Core domain: synchronisers
	localparam int NSYNC = 12;
	logic [NSYNC-1:0] csync_in;
	logic [NSYNC-1:0] csync_meta_reg;
	logic [NSYNC-1:0] csync_reg;
	logic [NSYNC-1:0] csync_prev_reg;
	ascs_cfg_s        cfg;

	assign csync_in = {i_chip_select_n, i_extended_sample_start, i_trigger_mode,
		i_long_sample, i_sclk_conv, i_res_12bit, conv_tgl_reg, sdone_tgl_reg,
		fstart_tgl_reg, ack_tgl_reg, 1'h0};

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			// Idle levels of chip select and extended start: no false edge
			csync_meta_reg <= 12'hC00;
			csync_reg      <= 12'hC00;
			csync_prev_reg <= 12'hC00;
		end else begin
			csync_meta_reg <= csync_in;
			csync_reg      <= csync_meta_reg;
			csync_prev_reg <= csync_reg;
		end
	end

	logic cs_n_s;
	logic cs_fall;
	logic extended_sample_start_rise;
	logic extended_sample_start_fall;
	logic conv_evt;
	logic sdone_evt;
	logic fs_evt;
	logic ack_s;
	logic frame_evt;
	logic start_pulse;

	assign cs_n_s      = csync_reg[11];
	assign cs_fall     = csync_prev_reg[11] && !csync_reg[11];
	assign extended_sample_start_rise = !csync_prev_reg[10] && csync_reg[10];
	assign extended_sample_start_fall = csync_prev_reg[10] && !csync_reg[10];
	assign cfg         = ascs_cfg_s'(csync_reg[9:5]);
	assign conv_evt    = csync_reg[4] != csync_prev_reg[4];
	assign sdone_evt   = csync_reg[3] != csync_prev_reg[3];
	assign fs_evt      = csync_reg[2] != csync_prev_reg[2];
	assign ack_s       = csync_reg[1];
	assign frame_evt   = (cfg.trig == TRIG_CS && cs_fall) || fs_evt || extended_sample_start_fall;

	// ======================================================================
	// Conversion sequencing
	ascs_state_e  state_reg;
	logic [15:0]  cnt_reg;
	logic [15:0]  osc_len;
	ascs_result_s sample_reg;
	logic         buf_in_ready;
	logic         store_ok;

	assign osc_len     = cfg.res_12bit ? 16'(OSC12) : 16'(OSC14);
	assign start_pulse = (state_reg == ST_IDLE) &&
		((cfg.trig == TRIG_EXT) ? extended_sample_start_rise : conv_evt);
	assign store_ok    = (state_reg == ST_STORE) && buf_in_ready;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 16'h0000;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					cnt_reg <= 16'h0001;
					if (start_pulse) begin
						state_reg <= ST_CONV;
					end
				end
				ST_CONV: begin
					cnt_reg <= cnt_reg + 16'h0001;
					// Extended starts have no running serial clock to time on
					if (cfg.sclk_conv && cfg.trig != TRIG_EXT) begin
						if (sdone_evt) begin
							state_reg <= ST_TAIL;
							cnt_reg   <= 16'h0001;
						end
					end else if (cnt_reg >= osc_len) begin
						state_reg <= ST_TAIL;
						cnt_reg   <= 16'h0001;
					end
				end
				ST_TAIL: begin
					cnt_reg <= cnt_reg + 16'h0001;
					if (cnt_reg >= 16'(TAIL_CYC)) begin
						state_reg <= ST_STORE;
					end
				end
				ST_STORE: begin
					// A full buffer holds the result here instead of dropping it
					if (buf_in_ready) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sample_reg <= '{code: `ASCS_ZERO_CODE};
		end else if (start_pulse) begin
			sample_reg.code <= cfg.res_12bit ?
				{~i_analog_code[13], i_analog_code[12:2], 2'h0} :
				{~i_analog_code[13], i_analog_code[12:0]};
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_end_of_conversion <= 1'h1;
		end else if (start_pulse) begin
			o_end_of_conversion <= 1'h0;
		end else if (state_reg == ST_TAIL && cnt_reg >= 16'(TAIL_CYC)) begin
			o_end_of_conversion <= 1'h1;
		end
	end

	// Setting the flag wins over a frame that releases it in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_conversion_done_n <= 1'h1;
		end else if (store_ok) begin
			o_conversion_done_n <= 1'h0;
		end else if (frame_evt) begin
			o_conversion_done_n <= 1'h1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_serial_data_out_oe <= 1'h0;
		end else begin
			o_serial_data_out_oe <= !cs_n_s;
		end
	end

	// ======================================================================
	// Result buffer and word hand-off to the link
	logic         buf_out_valid;
	ascs_result_s buf_out_data;
	logic         hold_busy;
	logic         pop;

	assign hold_busy = (req_tgl_reg != ack_s);
	assign pop       = buf_out_valid && !hold_busy;

	ascs_buf2 u_buf (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (state_reg == ST_STORE),
		.i_in_data   (sample_reg),
		.o_in_ready  (buf_in_ready),
		.o_out_valid (buf_out_valid),
		.o_out_data  (buf_out_data),
		.i_out_ready (!hold_busy)
	);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hold_reg    <= '{code: `ASCS_ZERO_CODE};
			req_tgl_reg <= 1'h0;
		end else if (pop) begin
			hold_reg    <= buf_out_data;
			req_tgl_reg <= ~req_tgl_reg;
		end
	end

	// ======================================================================
	// Checks
	logic [15:0] age_reg;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			age_reg <= 16'h0000;
		end else if (start_pulse) begin
			age_reg <= 16'h0001;
		end else if (state_reg == ST_CONV) begin
			age_reg <= age_reg + 16'h0001;
		end
	end

	a_eoc_falls_start: assert property (
		@(posedge i_clk) disable iff (i_rst)
		start_pulse |=> !o_end_of_conversion ##1 !o_end_of_conversion)
		else $error("end_of_conversion did not fall at conversion start");

	a_osc_conv_length: assert property (
		@(posedge i_clk) disable iff (i_rst)
		state_reg == ST_TAIL && $past(state_reg) == ST_CONV &&
		(!cfg.sclk_conv || cfg.trig == TRIG_EXT)
		|-> age_reg == osc_len + 16'h0001)
		else $error("oscillator conversion length wrong");

	a_tail_then_store: assert property (
		@(posedge i_clk) disable iff (i_rst)
		$rose(state_reg == ST_TAIL) |-> (state_reg == ST_TAIL) [*2] ##1 state_reg == ST_STORE)
		else $error("fixed conversion tail not honoured");

	a_done_after_store: assert property (
		@(posedge i_clk) disable iff (i_rst)
		store_ok |=> !o_conversion_done_n && o_end_of_conversion)
		else $error("done flag not asserted after conversion");

	a_done_release: assert property (
		@(posedge i_clk) disable iff (i_rst)
		frame_evt && !store_ok |=> o_conversion_done_n)
		else $error("done flag not released by new frame");

	a_oe_follows_cs: assert property (
		@(posedge i_clk) disable iff (i_rst)
		cs_n_s [*2] |-> !o_serial_data_out_oe)
		else $error("serial_data_out driven while deselected");

	a_offset_code: assert property (
		@(posedge i_clk) disable iff (i_rst)
		start_pulse |=> sample_reg.code[13] == !$past(i_analog_code[13]))
		else $error("result not offset binary");

	a_ext_start: assert property (
		@(posedge i_clk) disable iff (i_rst)
		extended_sample_start_rise && cfg.trig == TRIG_EXT && state_reg == ST_IDLE |=> state_reg == ST_CONV)
		else $error("extended start did not begin conversion");

	a_sdi_capture: assert property (
		@(negedge i_sclk) disable iff (i_rst || i_chip_select_n)
		1'b1 |=> sdi_shift_reg[0] == $past(i_serial_data_in))
		else $error("serial_data_in not captured on falling edge");

	a_sdo_shift: assert property (
		@(posedge i_sclk) disable iff (i_rst || i_chip_select_n)
		!load_now |=> o_serial_data_out == $past(sdo_shift_reg[`ASCS_FRAME_BITS-2]))
		else $error("serial_data_out not advanced on rising edge");

endmodule

// file: ascs_sequencer_tb.sv
// Self-checking bench of the conversion sequencer: both triggers, both
// sample lengths, both conversion clocks and variants, extended starts.
// Assumes ascs_host_model stands in for the host on the serial link.
`timescale 1ns/1ps

module ascs_sequencer_tb
	import ascs_pkg::*;
;
	logic        i_clk  = 1'b0;
	logic        i_rst  = 1'b1;
	logic [1:0]  trig   = 2'h0;
	logic        long_s = 1'b0;
	logic        sconv  = 1'b0;
	logic        res12  = 1'b0;
	logic [13:0] acode  = 14'h0000;
	wire         sclk, cs_n, fs, serial_data_in, ext, serial_data_out, sdo_oe, eoc, done_n;
	wire  [15:0] sdi_word;
	int          err_total = 0;
	int          compares  = 0;
	int          cyc       = 0;
	logic [15:0] q[$];

	always #5 i_clk = ~i_clk;

	ascs_sequencer #(.OSC_DIV(4)) u_ascs_sequencer (
		.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_chip_select_n(cs_n),
		.i_frame_sync(fs), .i_serial_data_in(serial_data_in), .i_extended_sample_start(ext),
		.i_trigger_mode(trig), .i_long_sample(long_s), .i_sclk_conv(sconv),
		.i_res_12bit(res12), .i_analog_code(acode), .o_serial_data_out(serial_data_out),
		.o_serial_data_out_oe(sdo_oe), .o_end_of_conversion(eoc),
		.o_conversion_done_n(done_n), .o_sdi_word(sdi_word));

	ascs_host_model u_ascs_host_model (
		.o_sclk(sclk), .o_chip_select_n(cs_n), .o_frame_sync(fs),
		.o_serial_data_in(serial_data_in), .o_extended_sample_start(ext),
		.i_serial_data_out(serial_data_out), .i_serial_data_out_oe(sdo_oe));

	// ==================================================================
	// Reporting
	task automatic end_of_test();
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			end_of_test();
		end
	end

	// ==================================================================
	// Helpers
	function automatic logic [15:0] fmt(input logic [13:0] c);
		fmt = {c ^ 14'h2000, 2'b00};
		if (res12) fmt = fmt & 16'hFFF0;
	endfunction

	task automatic set_mode(input logic [1:0] t, input logic l, s, r);
		@(negedge i_clk);
		trig   = t;
		long_s = l;
		sconv  = s;
		res12  = r;
		repeat (8) @(negedge i_clk);
	endtask

	// conv 0 skips the timing of done, used while results queue up
	task automatic measure(input int n, input int conv);
		int c;
		c = 0;
		wait (u_ascs_host_model.falls == n - 1);
		#100;
		check(eoc, 1'b1, "eoc early");
		if (conv > 0) check(done_n, 1'b1, "done kept");
		wait (u_ascs_host_model.falls == n);
		while (eoc === 1'b1 && c < 20) begin
			@(posedge i_clk);
			c++;
		end
		check(c <= 6, 1'b1, "eoc late");
		if (conv > 0) begin
			while (done_n === 1'b1 && c < conv + 40) begin
				@(posedge i_clk);
				c++;
			end
			check(c >= conv - (sconv ? 8 : 0) && c <= conv + 10, 1'b1, "conv");
			check(eoc, 1'b1, "eoc after");
		end
	endtask

	task automatic code_frame(input bit fsm, input int n, conv, input logic [13:0] c);
		logic [15:0] rx;
		logic [15:0] exp;
		logic [15:0] tx;
		int          extra;
		@(negedge i_clk);
		acode = c;
		tx    = {c, 2'b11} ^ 16'h5A5A;
		exp   = (q.size() > 0) ? q.pop_front() : 16'h0000;
		extra = sconv ? (res12 ? 52 : 72) : 0;
		u_ascs_host_model.falls = 0;
		fork
			u_ascs_host_model.frame(n + 1 + extra, tx, fsm, rx);
			measure(n, conv);
		join
		check(rx, exp, "sdo word");
		if (n == 16) check(sdi_word, tx, "sdi word");
		q.push_back(fmt(c));
	endtask

	task automatic ext_conv(input logic [13:0] c, input bit room);
		int k;
		k = 0;
		@(negedge i_clk);
		acode = c;
		u_ascs_host_model.ext_pulse(500.0);
		while (done_n === 1'b1 && k < 120) begin
			@(posedge i_clk);
			k++;
		end
		if (room) check(k >= 72 && k <= 82, 1'b1, "ext conv");
		else check(done_n, 1'b1, "full stall");
		q.push_back(fmt(c));
	endtask

	// ==================================================================
	// Scenarios
	task automatic sc_idle_noise();
		u_ascs_host_model.noise();
		#100;
		check(sdo_oe, 1'b0, "oe idle");
		check(sdi_word, 16'h0000, "sdi idle");
		check(eoc, 1'b1, "eoc idle");
	endtask

	task automatic sc_cs_short();
		code_frame(1'b0, 16, 72, 14'h0000);
		code_frame(1'b0, 16, 72, 14'h1FFF);
		code_frame(1'b0, 16, 72, 14'h2000);
		code_frame(1'b0, 16, 72, 14'h0ABC);
	endtask

	task automatic sc_long_12();
		set_mode(2'h0, 1'b1, 1'b0, 1'b1);
		code_frame(1'b0, 48, 52, 14'h0007);
		code_frame(1'b0, 48, 52, 14'h1230);
	endtask

	task automatic sc_sclk_conv();
		set_mode(2'h0, 1'b0, 1'b1, 1'b0);
		code_frame(1'b0, 16, 900, 14'h0100);
		set_mode(2'h0, 1'b0, 1'b1, 1'b1);
		code_frame(1'b0, 16, 650, 14'h3FF8);
	endtask

	task automatic sc_fs_trigger();
		set_mode(2'h1, 1'b0, 1'b0, 1'b0);
		code_frame(1'b1, 16, 72, 14'h1555);
		code_frame(1'b1, 16, 72, 14'h0000);
	endtask

	// The link holds one result; two more fill the buffer, a third must wait
	task automatic sc_ext_buffer();
		set_mode(2'h2, 1'b0, 1'b0, 1'b0);
		ext_conv(14'h0FF0, 1'b1);
		ext_conv(14'h3000, 1'b1);
		ext_conv(14'h1800, 1'b0);
		set_mode(2'h0, 1'b0, 1'b0, 1'b0);
		code_frame(1'b0, 16, 0, 14'h0040);
		code_frame(1'b0, 16, 0, 14'h0080);
		code_frame(1'b0, 16, 0, 14'h00C0);
	endtask

	initial begin
		repeat (4) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (6) @(negedge i_clk);
		sc_idle_noise();
		sc_cs_short();
		sc_long_12();
		sc_sclk_conv();
		sc_fs_trigger();
		sc_ext_buffer();
		end_of_test();
	end
endmodule
